// ===== core/uic_core.sv
// interrupt, line format and receive status logic of a serial element
// assumes apb master on clk; rx and tx datapaths run on clk too
// Operation
// - enable register's four bits gate five sources, upper zero
// - all enables clear: no interrupt output
// - five priority levels, highest one reported
// - ident bit 0 low while pending
// - line error interrupt until line status read
// - data available interrupt until buffer read
// - fifo time-out after four idle characters
// - tx empty cleared by ident read, write
// - modem change interrupt until modem read
// - ident upper bits follow fifo enable
// - format bits 1:0 pick five-eight data bits
// - bit 2 picks one, 1.5, two stops
// - receiver checks only first stop bit
// - bit 3 enables parity send and check
// - bit 4 selects even, else odd
// - bit 5 makes parity a fixed value
// - break bit forces serial output low
// - divisor select bit redirects low offsets
// - ready flag while received data unread
// - overrun on overwrite, cleared by status read
// - fifo overrun only when full, character dropped
// - status bits 1-4 raise line interrupt
// - fifo control bit 0 selects fifo mode
// - fifo mode: tx empty raised on empty
`timescale 1ns/1ps
`default_nettype none
module uic_core #(
  parameter int RX_DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive datapath
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_parity_in,
  input wire logic rx_stop_in,
  input wire logic rx_break,
  input wire logic char_tick,
  // transmit datapath
  input wire logic tx_empty,
  input wire logic tx_idle,
  input wire logic tx_line_in,
  output logic tx_wr_valid,
  output logic [7:0] tx_wr_data,
  output logic tx_parity_out,
  output logic tx_fifo_clear,
  output logic serial_out,
  // line format to datapaths
  output logic [1:0] word_len_sel,
  output logic [2:0] stop_halfbits,
  output logic parity_enable,
  output logic fifo_mode,
  output logic [15:0] divisor,
  // modem pins
  input wire logic cts_pin,
  input wire logic dsr_pin,
  input wire logic ri_pin,
  input wire logic dcd_pin,
  // interrupt
  output logic irq_output
);
  localparam int AW = $clog2(RX_DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(RX_DEPTH);

  logic [3:0] irq_enable_reg;
  logic [7:0] line_format_reg;
  logic [7:0] dl_lo_reg, dl_hi_reg;
  logic [1:0] trig_sel_reg;
  logic [10:0] rx_mem [RX_DEPTH];
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [AW:0] rx_cnt_reg;
  logic overrun_reg, perr_reg, ferr_reg, brk_reg;
  logic tx_holding_empty_pend_reg, tx_empty_d_reg;
  logic [3:0] modem_s1_reg, modem_s2_reg, modem_d_reg, modem_delta_reg;
  logic tmo;
  logic [3:0] ident;
  logic setup, wr_acc, rd_acc, divisor_select_bit;
  logic rd_data, rd_lsr, rd_iir, rd_msr, wr_thr, wr_fcr;
  logic pop, rx_full, accept, overwrite, overrun_evt, head_load, rx_clear;
  logic [10:0] in_entry, head_entry;
  logic [4:0] trig_lvl;
  logic rda_cond;

  // mask of active data bits for the chosen length
  function automatic logic [7:0] len_mask(input logic [1:0] wls);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - wls);
    return m;
  endfunction

  // parity bit to send or expect for one character
  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] line_format_control);
    logic p;
    p = ^(d & len_mask(line_format_control[uic_pkg::LCR_WLS +: 2]));
    if (line_format_control[uic_pkg::LCR_STICK]) begin
      p = ~line_format_control[uic_pkg::LCR_EPS];
    end else if (!line_format_control[uic_pkg::LCR_EPS]) begin
      p = ~p;
    end
    return p;
  endfunction

  // apb phase and address decode
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign divisor_select_bit = line_format_reg[uic_pkg::LCR_DIVISOR_SELECT_BIT];
  assign rd_data = rd_acc && !divisor_select_bit && paddr[4:0] == uic_pkg::ADDR_DATA;
  assign rd_lsr = rd_acc && paddr[4:0] == uic_pkg::ADDR_LSR;
  assign rd_iir = rd_acc && paddr[4:0] == uic_pkg::ADDR_IIR;
  assign rd_msr = rd_acc && paddr[4:0] == uic_pkg::ADDR_MSR;
  assign wr_thr = wr_acc && !divisor_select_bit && paddr[4:0] == uic_pkg::ADDR_DATA;
  assign wr_fcr = wr_acc && paddr[4:0] == uic_pkg::ADDR_IIR;

  // writable control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_enable_reg <= uic_pkg::IER_RST;
      line_format_reg <= uic_pkg::LCR_RST;
      dl_lo_reg <= uic_pkg::DIV_RST[7:0];
      dl_hi_reg <= uic_pkg::DIV_RST[15:8];
      fifo_mode <= 1'b0;
      trig_sel_reg <= 2'h0;
    end else if (wr_acc) begin
      case (paddr[4:0])
        uic_pkg::ADDR_DATA: begin
          if (divisor_select_bit) begin
            dl_lo_reg <= pwdata[7:0];
          end
        end
        uic_pkg::ADDR_IER: begin
          if (divisor_select_bit) begin
            dl_hi_reg <= pwdata[7:0];
          end else begin
            irq_enable_reg <= pwdata[3:0];
          end
        end
        uic_pkg::ADDR_IIR: begin
          fifo_mode <= pwdata[uic_pkg::FCR_EN];
          if (pwdata[uic_pkg::FCR_EN]) begin
            trig_sel_reg <= pwdata[uic_pkg::FCR_TRIG +: 2];
          end
        end
        uic_pkg::ADDR_LCR: begin
          line_format_reg <= pwdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // format outputs to the datapaths
  assign word_len_sel = line_format_reg[uic_pkg::LCR_WLS +: 2];
  assign parity_enable = line_format_reg[uic_pkg::LCR_PEN];
  assign divisor = {dl_hi_reg, dl_lo_reg};

  // registered stop length
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_halfbits <= uic_pkg::STOP_ONE;
    end else if (!line_format_reg[uic_pkg::LCR_STB]) begin
      stop_halfbits <= uic_pkg::STOP_ONE;
    // shorter stop for five bits vs more
    end else if (word_len_sel == 2'h0) begin
      stop_halfbits <= uic_pkg::STOP_ONE_HALF;
    end else begin
      stop_halfbits <= uic_pkg::STOP_TWO;
    end
  end

  // transmit hand-off and line output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_wr_valid <= 1'b0;
      tx_wr_data <= 8'h00;
      tx_parity_out <= 1'b0;
      tx_fifo_clear <= 1'b0;
      serial_out <= 1'b1;
    end else begin
      tx_wr_valid <= wr_thr;
      tx_fifo_clear <= wr_fcr && (pwdata[uic_pkg::FCR_TXCLR] ||
                       pwdata[uic_pkg::FCR_EN] != fifo_mode);
      if (wr_thr) begin
        tx_wr_data <= pwdata[7:0] & len_mask(word_len_sel);
        tx_parity_out <= par_bit(pwdata[7:0], line_format_reg);
      end
      serial_out <= tx_line_in && !line_format_reg[uic_pkg::LCR_BRK];
    end
  end

  // receive buffer control
  assign pop = rd_data && rx_cnt_reg != '0;
  assign rx_full = fifo_mode ? rx_cnt_reg == DEPTH_CNT : rx_cnt_reg != '0;
  assign accept = rx_char_valid && (!rx_full || pop);
  assign overwrite = rx_char_valid && rx_full && !pop && !fifo_mode;
  // fifo full: character lost, flag at once
  assign overrun_evt = rx_char_valid && rx_full && !pop;
  assign rx_clear = wr_fcr && (pwdata[uic_pkg::FCR_RXCLR] ||
                    pwdata[uic_pkg::FCR_EN] != fifo_mode);
  assign head_entry = rx_mem[rd_ptr_reg];

  // incoming entry: data, break, framing, parity flags
  always_comb begin
    in_entry[7:0] = rx_break ? 8'h00 : (rx_char_data & len_mask(word_len_sel));
    in_entry[10] = rx_break;
    // only the first stop bit is checked
    in_entry[9] = !rx_break && !rx_stop_in;
    in_entry[8] = !rx_break && line_format_reg[uic_pkg::LCR_PEN] &&
                  (rx_parity_in != par_bit(rx_char_data, line_format_reg));
  end

  // receive storage
  always_ff @(posedge clk) begin
    if (accept) begin
      rx_mem[wr_ptr_reg] <= in_entry;
    end else if (overwrite) begin
      rx_mem[rd_ptr_reg] <= in_entry;
    end
  end

  // receive pointers and count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      rx_cnt_reg <= '0;
    end else if (rx_clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      rx_cnt_reg <= '0;
    end else begin
      if (accept) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      rx_cnt_reg <= rx_cnt_reg + (AW + 1)'(accept) - (AW + 1)'(pop);
    end
  end

  // error flags of the character now at the head
  assign head_load = (accept && (rx_cnt_reg == '0 || (pop && rx_cnt_reg == 1))) ||
                     overwrite;

  // line status error flags, set wins over read clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overrun_reg <= 1'b0;
      perr_reg <= 1'b0;
      ferr_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else begin
      overrun_reg <= overrun_evt || (overrun_reg && !rd_lsr);
      if (head_load) begin
        perr_reg <= in_entry[8] || (perr_reg && !rd_lsr);
        ferr_reg <= in_entry[9] || (ferr_reg && !rd_lsr);
        brk_reg <= in_entry[10] || (brk_reg && !rd_lsr);
      end else if (pop && rx_cnt_reg > 1) begin
        perr_reg <= rx_mem[rd_ptr_reg + 1'b1][8] || (perr_reg && !rd_lsr);
        ferr_reg <= rx_mem[rd_ptr_reg + 1'b1][9] || (ferr_reg && !rd_lsr);
        brk_reg <= rx_mem[rd_ptr_reg + 1'b1][10] || (brk_reg && !rd_lsr);
      end else if (rd_lsr) begin
        perr_reg <= 1'b0;
        ferr_reg <= 1'b0;
        brk_reg <= 1'b0;
      end
    end
  end

  // trigger level decode
  always_comb begin
    case (trig_sel_reg)
      2'h0: trig_lvl = uic_pkg::TRIG_1;
      2'h1: trig_lvl = uic_pkg::TRIG_4;
      2'h2: trig_lvl = uic_pkg::TRIG_8;
      default: trig_lvl = uic_pkg::TRIG_14;
    endcase
  end

  // data available by presence or trigger
  assign rda_cond = fifo_mode ? (5'(rx_cnt_reg) >= trig_lvl) : rx_cnt_reg != '0;

  // time-out with data held and no traffic
  uic_rx_timeout u_tmo (
    .clk(clk),
    .rst(rst),
    .armed(fifo_mode && rx_cnt_reg != '0),
    .activity(accept || pop),
    .char_tick(char_tick),
    .timed_out(tmo)
  );

  // transmit empty interrupt condition
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_empty_d_reg <= 1'b0;
      tx_holding_empty_pend_reg <= 1'b0;
    end else begin
      tx_empty_d_reg <= tx_empty;
      // raised when the holding side empties
      if ((tx_empty && !tx_empty_d_reg) ||
          (tx_empty && wr_fcr && pwdata[uic_pkg::FCR_EN] != fifo_mode)) begin
        tx_holding_empty_pend_reg <= 1'b1;
      // cleared by ident read or data write
      end else if (wr_thr || (rd_iir && ident == uic_pkg::IIR_TX_HOLDING_EMPTY)) begin
        tx_holding_empty_pend_reg <= 1'b0;
      end
    end
  end

  // modem pin synchronisers and change flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modem_s1_reg <= 4'h0;
      modem_s2_reg <= 4'h0;
      modem_d_reg <= 4'h0;
      modem_delta_reg <= 4'h0;
    end else begin
      modem_s1_reg <= {dcd_pin, ri_pin, dsr_pin, cts_pin};
      modem_s2_reg <= modem_s1_reg;
      modem_d_reg <= modem_s2_reg;
      // change flags cleared by modem read
      modem_delta_reg[0] <= (modem_s2_reg[0] ^ modem_d_reg[0]) ||
                            (modem_delta_reg[0] && !rd_msr);
      modem_delta_reg[1] <= (modem_s2_reg[1] ^ modem_d_reg[1]) ||
                            (modem_delta_reg[1] && !rd_msr);
      modem_delta_reg[2] <= (modem_s2_reg[2] && !modem_d_reg[2]) ||
                            (modem_delta_reg[2] && !rd_msr);
      modem_delta_reg[3] <= (modem_s2_reg[3] ^ modem_d_reg[3]) ||
                            (modem_delta_reg[3] && !rd_msr);
    end
  end

  uic_irq_prio u_prio (
    // status bits 1-4 feed line interrupt
    .line_err(irq_enable_reg[uic_pkg::IER_RLS] &&
              (overrun_reg || perr_reg || ferr_reg || brk_reg)),
    .rx_avail(irq_enable_reg[uic_pkg::IER_RDA] && rda_cond),
    .rx_tmo(irq_enable_reg[uic_pkg::IER_RDA] && tmo),
    .tx_holding_empty(irq_enable_reg[uic_pkg::IER_TX_HOLDING_EMPTY] && tx_holding_empty_pend_reg),
    .modem(irq_enable_reg[uic_pkg::IER_MS] && modem_delta_reg != 4'h0),
    .ident(ident)
  );

  // output is the inverse of ident bit 0, one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_output <= 1'b0;
    end else begin
      irq_output <= !ident[0];
    end
  end

  // read data, captured in the setup cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      if (setup) begin
        prdata <= 32'h0000_0000;
        case (paddr[4:0])
          uic_pkg::ADDR_DATA: begin
            prdata[7:0] <= divisor_select_bit ? dl_lo_reg : head_entry[7:0];
          end
          uic_pkg::ADDR_IER: begin
            prdata[7:0] <= divisor_select_bit ? dl_hi_reg : {4'h0, irq_enable_reg};
          end
          uic_pkg::ADDR_IIR: begin
            prdata[7:0] <= {fifo_mode, fifo_mode, 2'h0, ident};
          end
          uic_pkg::ADDR_LCR: begin
            prdata[7:0] <= line_format_reg;
          end
          uic_pkg::ADDR_LSR: begin
            prdata[7:0] <= {1'b0, tx_idle, tx_empty, brk_reg, ferr_reg, perr_reg,
                            overrun_reg, rx_cnt_reg != '0};
          end
          uic_pkg::ADDR_MSR: begin
            prdata[7:0] <= {modem_s2_reg, modem_delta_reg};
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== core/uic_irq_prio.sv
// five-level interrupt priority encoder
// assumes pending sources are already gated by their enables
`timescale 1ns/1ps
`default_nettype none
module uic_irq_prio (
  // gated sources
  input wire logic line_err,
  input wire logic rx_avail,
  input wire logic rx_tmo,
  input wire logic tx_holding_empty,
  input wire logic modem,
  // encoded identity
  output logic [3:0] ident
);
  // highest pending source wins
  always_comb begin
    if (line_err) begin
      ident = uic_pkg::IIR_RLS;
    end else if (rx_avail) begin
      ident = uic_pkg::IIR_RDA;
    end else if (rx_tmo) begin
      ident = uic_pkg::IIR_TMO;
    end else if (tx_holding_empty) begin
      ident = uic_pkg::IIR_TX_HOLDING_EMPTY;
    end else if (modem) begin
      ident = uic_pkg::IIR_MS;
    end else begin
      ident = uic_pkg::IIR_NONE;
    end
  end
endmodule
`default_nettype wire

// ===== core/uic_pkg.sv
// constants shared by the line control and interrupt block
// assumes a 32-bit apb master and a 20 mhz system clock
package uic_pkg;
  // system clock rate
  localparam int CLK_HZ = 20_000_000;
  // apb byte addresses
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_DATA = 5'h00;
  localparam logic [4:0] ADDR_IER = 5'h04;
  localparam logic [4:0] ADDR_IIR = 5'h08;
  localparam logic [4:0] ADDR_LCR = 5'h0C;
  localparam logic [4:0] ADDR_LSR = 5'h14;
  localparam logic [4:0] ADDR_MSR = 5'h18;
  // interrupt enable fields
  localparam int IER_RDA = 0;
  localparam int IER_TX_HOLDING_EMPTY = 1;
  localparam int IER_RLS = 2;
  localparam int IER_MS = 3;
  // line format fields
  localparam int LCR_WLS = 0;
  localparam int LCR_STB = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_EPS = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_BRK = 6;
  localparam int LCR_DIVISOR_SELECT_BIT = 7;
  // fifo control fields
  localparam int FCR_EN = 0;
  localparam int FCR_RXCLR = 1;
  localparam int FCR_TXCLR = 2;
  localparam int FCR_TRIG = 6;
  // identification codes, low nibble
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_RLS = 4'h6;
  localparam logic [3:0] IIR_RDA = 4'h4;
  localparam logic [3:0] IIR_TMO = 4'hC;
  localparam logic [3:0] IIR_TX_HOLDING_EMPTY = 4'h2;
  localparam logic [3:0] IIR_MS = 4'h0;
  // reset values
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [3:0] IER_RST = 4'h0;
  localparam logic [15:0] DIV_RST = 16'h0000;
  // receive trigger levels in bytes
  localparam logic [4:0] TRIG_1 = 5'h01;
  localparam logic [4:0] TRIG_4 = 5'h04;
  localparam logic [4:0] TRIG_8 = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0E;
  // idle character times before a receive time-out
  localparam logic [2:0] TMO_CHARS = 3'h4;
  // stop length in half bit times
  localparam logic [2:0] STOP_ONE = 3'h2;
  localparam logic [2:0] STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_TWO = 3'h4;
endpackage

// ===== core/uic_rx_timeout.sv
// receive character time-out timer
// assumes char_tick pulses once per character time on clk
`timescale 1ns/1ps
`default_nettype none
module uic_rx_timeout (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // conditions
  input wire logic armed,
  input wire logic activity,
  input wire logic char_tick,
  // result
  output logic timed_out
);
  logic [2:0] idle_reg;

  // count idle character times while data waits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_reg <= 3'h0;
      timed_out <= 1'b0;
    end else if (!armed || activity) begin
      idle_reg <= 3'h0;
      timed_out <= 1'b0;
    end else if (char_tick && !timed_out) begin
      idle_reg <= idle_reg + 3'h1;
      timed_out <= (idle_reg + 3'h1) == uic_pkg::TMO_CHARS;
    end
  end
endmodule
`default_nettype wire

// ===== dv/uic_core_properties.sv
// concurrent checks on the serial control core ports
// assumes one clock domain and shadows format and enable writes
`timescale 1ns/1ps
`default_nettype none
module uic_core_properties (
  // clock and reset
  input wire logic clk, rst,
  // apb
  input wire logic psel, penable, pwrite, pready,
  input wire logic [31:0] paddr, pwdata, prdata,
  // datapath side
  input wire logic tx_wr_valid, tx_parity_out, tx_line_in, serial_out,
  input wire logic [7:0] tx_wr_data,
  input wire logic [2:0] stop_halfbits,
  input wire logic [15:0] divisor,
  input wire logic fifo_mode, irq_output
);
  logic [7:0] lcr_q;
  logic [3:0] ier_q;
  logic wr, rd;
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;
  // shadow copies of format and enable registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lcr_q <= 8'h00;
      ier_q <= 4'h0;
    end else if (wr && paddr[4:0] == uic_pkg::ADDR_LCR) begin
      lcr_q <= pwdata[7:0];
    end else if (wr && paddr[4:0] == uic_pkg::ADDR_IER && !lcr_q[7]) begin
      ier_q <= pwdata[3:0];
    end
  end
  function automatic logic [7:0] msk(input logic [1:0] l);
    msk = 8'hFF >> (2'h3 - l);
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_thr_wr;
    wr && paddr[4:0] == uic_pkg::ADDR_DATA && !lcr_q[7];
  endsequence
  sequence s_pulse;
    tx_wr_valid ##1 !tx_wr_valid;
  endsequence
  sequence s_quiet;
    (ier_q == 4'h0) [*3];
  endsequence
  chk_tx_write_pulse: assert property (s_thr_wr |=> s_pulse)
    else $error("tx write pulse wrong");
  chk_tx_data_mask: assert property (s_thr_wr |=> tx_wr_data == ($past(pwdata[7:0]) & msk(lcr_q[1:0])))
    else $error("tx data not masked");
  chk_tx_parity_bit: assert property (tx_wr_valid && lcr_q[3] |->
    tx_parity_out == (lcr_q[5] ? !lcr_q[4] : (^tx_wr_data ^ !lcr_q[4])))
    else $error("tx parity wrong");
  chk_apb_zero_wait: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready timing wrong");
  chk_enable_readback: assert property (rd && paddr[4:0] == uic_pkg::ADDR_IER && !lcr_q[7] |->
    prdata == {28'h0, ier_q})
    else $error("enable readback wrong");
  chk_ident_upper_bits: assert property (rd && paddr[4:0] == uic_pkg::ADDR_IIR |->
    prdata[7:4] == {fifo_mode, fifo_mode, 2'h0} && (fifo_mode || !prdata[3]))
    else $error("ident upper bits wrong");
  chk_irq_all_off: assert property (s_quiet |-> !irq_output)
    else $error("irq with all enables clear");
  chk_stop_bit_count: assert property (stop_halfbits ==
    (!$past(lcr_q[2]) ? 3'h2 : ($past(lcr_q[1:0]) == 2'h0 ? 3'h3 : 3'h4)))
    else $error("stop length wrong");
  chk_break_forces_low: assert property ($past(lcr_q[6]) |-> !serial_out)
    else $error("break not forcing low");
  chk_line_passes_through: assert property (!$past(lcr_q[6]) |-> serial_out == $past(tx_line_in))
    else $error("serial out not following");
  chk_divisor_low_write: assert property (wr && paddr[4:0] == uic_pkg::ADDR_DATA && lcr_q[7] |=>
    divisor[7:0] == $past(pwdata[7:0]) && !tx_wr_valid)
    else $error("divisor low write wrong");
endmodule
bind uic_core uic_core_properties u_chk (.clk, .rst, .psel, .penable, .pwrite, .pready, .paddr,
  .pwdata, .prdata, .tx_wr_valid, .tx_parity_out, .tx_line_in, .serial_out, .tx_wr_data,
  .stop_halfbits, .divisor, .fifo_mode, .irq_output);
`default_nettype wire

// ===== dv/uic_core_tb.sv
// self-checking bench for the serial control core
// assumes apb access at byte offsets and a receive buffer of four
`timescale 1ns/1ps
`default_nettype none
module uic_core_tb;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic pready, pslverr, err, rx_char_valid = 1'b0, rx_stop_in = 1'b1, char_tick = 1'b0;
  logic rx_break = 1'b0;
  logic [7:0] rx_char_data = 8'h00, tx_wr_data, q;
  logic cts_pin = 1'b0, tx_wr_valid, tx_empty, tx_idle, tx_line_in, serial_out, irq_output;
  logic [15:0] divisor;
  logic [7:0] fmt [6] = '{8'h04, 8'h0D, 8'h1E, 8'h2F, 8'h3B, 8'h0B};
  int fail_count = 0, checks = 0;
  // 20 mhz clock
  always #25 clk = ~clk;
  uic_core #(.RX_DEPTH(4)) u_uic_core (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_char_valid, .rx_char_data, .rx_parity_in(1'b0), .rx_stop_in,
    .rx_break, .char_tick, .tx_empty, .tx_idle, .tx_line_in, .tx_wr_valid, .tx_wr_data,
    .tx_parity_out(), .tx_fifo_clear(), .serial_out, .word_len_sel(), .stop_halfbits(),
    .parity_enable(), .fifo_mode(), .divisor, .cts_pin, .dsr_pin(1'b0), .ri_pin(1'b0),
    .dcd_pin(1'b0), .irq_output);
  uic_tx_model u_uic_tx_model (.clk, .rst, .tx_wr_valid, .tx_empty, .tx_idle, .tx_line_in);
  task automatic final_report;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, setup then access until pready
  task automatic apb(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {27'h0, a};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fail_count++;
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    apb(1'b0, a, 8'h00);
    cmp(q & m, e);
  endtask
  task automatic push(input logic [7:0] d, input logic s);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    rx_stop_in <= s;
    @(posedge clk);
    rx_char_valid <= 1'b0;
    rx_stop_in <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(5'h08, 8'h01);
    rd(5'h04, 8'h00);
    apb(1'b0, 5'h10, 8'h00);
    cmp({7'h0, err}, 8'h01);
    apb(1'b1, 5'h04, 8'hFF);
    rd(5'h04, 8'h0F);
    cmp({7'h0, irq_output}, 8'h01);
    rd(5'h08, 8'h02);
    rd(5'h08, 8'h01);
    cmp({7'h0, irq_output}, 8'h00);
    push(8'h55, 1'b1);
    rd(5'h08, 8'h04);
    push(8'hAA, 1'b1);
    rd(5'h08, 8'h06);
    rd(5'h14, 8'h03, 8'h1F);
    rd(5'h08, 8'h04);
    rd(5'h00, 8'h0A);
    rd(5'h14, 8'h00, 8'h1F);
    push(8'h13, 1'b0);
    rd(5'h14, 8'h09, 8'h1F);
    rd(5'h00, 8'h13);
    rd(5'h08, 8'h01);
    // a break character is stored as zero with its flag
    rx_break <= 1'b1;
    push(8'hFF, 1'b1);
    rx_break <= 1'b0;
    rd(5'h14, 8'h11, 8'h1F);
    rd(5'h00, 8'h00);
    cts_pin <= 1'b1;
    repeat (6) @(posedge clk);
    rd(5'h08, 8'h00);
    apb(1'b0, 5'h18, 8'h00);
    rd(5'h08, 8'h01);
    apb(1'b1, 5'h04, 8'h00);
    push(8'h07, 1'b1);
    cmp({7'h0, irq_output}, 8'h00);
    rd(5'h08, 8'h01);
    rd(5'h00, 8'h07);
    foreach (fmt[i]) begin
      apb(1'b1, 5'h0C, fmt[i]);
      rd(5'h0C, fmt[i]);
      apb(1'b1, 5'h00, 8'hA7);
    end
    apb(1'b1, 5'h0C, 8'h43);
    apb(1'b1, 5'h00, 8'h5A);
    cmp({7'h0, serial_out}, 8'h00);
    apb(1'b1, 5'h0C, 8'h83);
    apb(1'b1, 5'h00, 8'h34);
    apb(1'b1, 5'h04, 8'h12);
    cmp(divisor[15:8], 8'h12);
    cmp(divisor[7:0], 8'h34);
    apb(1'b1, 5'h0C, 8'h03);
    rd(5'h04, 8'h00);
    apb(1'b1, 5'h04, 8'h01);
    apb(1'b1, 5'h08, 8'h41);
    rd(5'h08, 8'hC1);
    push(8'h21, 1'b1);
    rd(5'h08, 8'hC1);
    repeat (5) begin
      char_tick <= 1'b1;
      @(posedge clk);
      char_tick <= 1'b0;
      @(posedge clk);
    end
    rd(5'h08, 8'hCC);
    rd(5'h00, 8'h21);
    rd(5'h08, 8'hC1);
    repeat (5) push(8'h44, 1'b1);
    rd(5'h14, 8'h03, 8'h03);
    final_report;
  end
  // watchdog against a hung transfer
  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    final_report;
  end
endmodule
`default_nettype wire

// ===== dv/uic_tx_model.sv
// transmitter stand-in facing the core's transmit side
// assumes tx_wr_valid pulses once per written byte on clk
`timescale 1ns/1ps
`default_nettype none
module uic_tx_model (
  // clock and reset
  input wire logic clk, rst,
  // from core
  input wire logic tx_wr_valid,
  // to core
  output logic tx_empty, tx_idle, tx_line_in
);
  logic [3:0] busy_cnt;
  // each byte keeps the holder busy for twelve cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt <= 4'h0;
    end else if (tx_wr_valid) begin
      busy_cnt <= 4'hC;
    end else if (busy_cnt != 4'h0) begin
      busy_cnt <= busy_cnt - 4'h1;
    end
  end
  // line toggles while busy, marks when idle
  assign tx_empty = (busy_cnt == 4'h0);
  assign tx_idle = tx_empty;
  assign tx_line_in = busy_cnt[0] | tx_empty;
endmodule
`default_nettype wire
